// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
  import virt_cpu_if_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rdata;
  logic        deact_valid;
  logic [9:0]  deact_phys_id;
  int          n_errors = 0;
  int          compares = 0;

  always #50 clk = ~clk;

  virt_cpu_if uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .deact_valid(deact_valid),
    .deact_phys_id(deact_phys_id));

  // ==========================================================
  // helpers: each bus task starts just after a clock edge
  function automatic logic [31:0] le(int hw, int g1, logic [1:0] st,
    logic [4:0] p, logic [9:0] pid, logic [9:0] vid);
    le = {hw[0], g1[0], st, p, 3'h0, pid, vid};
  endfunction

  function automatic logic [7:0] la(int n);
    la = OFF_LIST_BASE + 8'(n * 4);
  endfunction

  task automatic ck(logic [31:0] g, logic [31:0] e, string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, string m);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    ck(rdata, e, m);
  endtask

  task automatic eoi(logic [9:0] vid, logic [10:0] e, string m);
    wr(OFF_ALIAS_EOI, {22'h0, vid});
    ck({21'h0, deact_valid, deact_phys_id}, {21'h0, e}, m);
    @(posedge clk);
    #1;
    ck({31'h0, deact_valid}, 32'h0, "deact pulse length");
  endtask

  task automatic tend(string s);
    $display("test %s ended, errors %0d", s, n_errors);
  endtask

  task automatic test_done;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    $display("MISMATCH %0t run too long", $time);
    test_done;
  end

  // ==========================================================
  // tests
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    rd(OFF_ACT_PRI, 32'h0, "bitmap reset");
    rd(OFF_RUN_PRI, 32'hF8, "idle priority");
    rd(OFF_HIGH_PEND, 32'h3FF, "none pending");
    rd(OFF_ALIAS_ACK, 32'h3FF, "nothing to ack");
    rd(8'h3C, 32'h0, "unmapped read");
    wr(OFF_ALIAS_BP, 32'h0);
    rd(OFF_ALIAS_BP, 32'h3, "alias bp floor");
    tend("reset");
    wr(la(0), le(0, 1, ST_ACT_PEND, 5'h02, 10'h0, 10'h005));
    wr(la(1), le(0, 1, ST_PENDING, 5'h04, 10'h003, 10'h020));
    rd(OFF_HIGH_PEND, 32'h3FE, "group one hidden");
    wr(OFF_CTRL, 32'hB);
    rd(OFF_HIGH_PEND, 32'hC20, "group one with cpu");
    wr(la(2), le(1, 0, ST_PENDING, 5'h01, 10'h155, 10'h030));
    rd(OFF_HIGH_PEND, 32'h30, "group zero hardware");
    tend("pending");
    wr(OFF_PRI_MASK, 32'hF8);
    rd(OFF_ALIAS_ACK, 32'h3FF, "group zero winner");
    rd(la(2), le(1, 0, ST_PENDING, 5'h01, 10'h155, 10'h030), "kept");
    wr(la(2), 32'h0);
    wr(OFF_PRI_MASK, 32'h20);
    rd(OFF_ALIAS_ACK, 32'h3FF, "masked");
    wr(OFF_CTRL, 32'h3);
    wr(OFF_PRI_MASK, 32'hF8);
    rd(OFF_ALIAS_ACK, 32'h3FF, "hyp off");
    wr(OFF_CTRL, 32'h9);
    rd(OFF_ALIAS_ACK, 32'hC20, "group one ack");
    rd(la(1), le(0, 1, ST_ACTIVE, 5'h04, 10'h3, 10'h20), "active");
    rd(OFF_ACT_PRI, 32'h10, "bitmap set");
    rd(OFF_RUN_PRI, 32'h20, "running");
    wr(la(3), le(1, 1, ST_PENDING, 5'h05, 10'h2AA, 10'h040));
    rd(OFF_ALIAS_ACK, 32'h3FF, "below running");
    tend("acknowledge");
    eoi(10'h020, 11'h0, "software eoi");
    rd(la(1), le(0, 1, ST_INVALID, 5'h04, 10'h3, 10'h20), "gone");
    rd(OFF_ACT_PRI, 32'h0, "bitmap clear");
    rd(OFF_RUN_PRI, 32'hF8, "drop to idle");
    wr(OFF_ALIAS_BP, 32'h4);
    rd(OFF_ALIAS_ACK, 32'h40, "hw ack no cpu");
    rd(OFF_ACT_PRI, 32'h10, "split point");
    eoi(10'h040, 11'h6AA, "hw deactivate");
    rd(la(3), le(1, 1, ST_INVALID, 5'h05, 10'h2AA, 10'h40), "off");
    wr(OFF_ACT_PRI, 32'h30);
    eoi(10'h005, 11'h2AA, "active pending");
    rd(la(0), le(0, 1, ST_PENDING, 5'h02, 10'h0, 10'h5), "back");
    rd(OFF_RUN_PRI, 32'h28, "lowest bit cleared");
    tend("end of interrupt");
    wr(OFF_CTRL, 32'hD);
    wr(la(0), le(1, 1, ST_ACTIVE, 5'h02, 10'h111, 10'h005));
    eoi(10'h005, 11'h2AA, "split mode");
    rd(la(0), le(1, 1, ST_ACTIVE, 5'h02, 10'h111, 10'h5), "held");
    wr(OFF_CTRL, 32'h9);
    wr(la(0), le(1, 0, ST_ACTIVE, 5'h02, 10'h111, 10'h005));
    eoi(10'h005, 11'h2AA, "group zero");
    tend("modes");
    test_done;
  end
endmodule

// ---- dv/virt_cpu_if_properties.sv ----
`timescale 1ns/10ps
module virt_cpu_if_checker
  import virt_cpu_if_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  input wire logic        deact_valid,
  input wire logic [9:0]  deact_phys_id
);
  // ==========================================================
  // read results and deactivate requests
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_run_pri_shape: assert property (
    $past(rd_en) && $past(addr) == OFF_RUN_PRI
    |-> rdata[31:8] == 24'h0 && rdata[2:0] == 3'h0)
    else $error("running priority has stray bits");
  a_idle_run_pri: assert property (
    rd_en && addr == OFF_ACT_PRI ##1 rdata == 32'h0 && rd_en
    && addr == OFF_RUN_PRI |=> rdata == {24'h0, RUN_PRI_IDLE})
    else $error("idle running priority wrong");
  a_pend_shape: assert property (
    $past(rd_en) && $past(addr) == OFF_HIGH_PEND |-> rdata[31:13] == 19'h0)
    else $error("highest pending has stray bits");
  a_ack_no_hidden: assert property (
    $past(rd_en) && $past(addr) == OFF_ALIAS_ACK
    |-> rdata[31:13] == 19'h0 && rdata[9:0] != ID_GROUP_ONE_BIT_HIDDEN)
    else $error("alias acknowledge returned hidden id");
  a_ack_spur_clean: assert property (
    $past(rd_en) && $past(addr) == OFF_ALIAS_ACK
    && rdata[9:0] == ID_SPURIOUS |-> rdata[12:10] == 3'h0)
    else $error("spurious id carries source cpu");
  a_abp_floor: assert property (
    $past(rd_en) && $past(addr) == OFF_ALIAS_BP
    |-> rdata[31:3] == 29'h0 && rdata[2:0] >= ALIAS_BP_MIN)
    else $error("alias binary point below floor");
  a_deact_cause: assert property (
    deact_valid |-> $past(wr_en) && $past(addr) == OFF_ALIAS_EOI)
    else $error("deactivate without end of interrupt write");
  a_deact_id_hold: assert property (
    !deact_valid |-> $stable(deact_phys_id))
    else $error("physical id changed without request");
endmodule

bind virt_cpu_if virt_cpu_if_checker chk_i (
  .clk           (clk),
  .rst_n         (rst_n),
  .addr          (addr),
  .wdata         (wdata),
  .wr_en         (wr_en),
  .rd_en         (rd_en),
  .rdata         (rdata),
  .deact_valid   (deact_valid),
  .deact_phys_id (deact_phys_id)
);

// ---- src/virt_cpu_if.sv ----
`timescale 1ns/10ps
module virt_cpu_if
  import virt_cpu_if_pkg::*;
#(
  parameter int NUM_ENTRIES = 4
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  output logic             deact_valid,
  output logic      [9:0]  deact_phys_id
);

  localparam int IDX_W = (NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1;

  // ==========================================================
  // helpers
  // mask keeping the group priority bits for a given binary point
  function automatic logic [7:0] group_mask(input logic [2:0] bp);
    logic [7:0] m;
    m = 8'hFF << (4'(bp) + 4'h1);
    return m;
  endfunction

  // an entry is treated as owning an active instance
  function automatic logic is_active(input logic [1:0] st);
    return (st == ST_ACTIVE) || (st == ST_ACT_PEND);
  endfunction

  // ==========================================================
  // state
  logic [31:0] list_entry_reg [NUM_ENTRIES];
  logic [3:0]  ctrl_reg;
  logic [7:0]  pri_mask_reg;
  logic [2:0]  bin_point_reg;
  logic [2:0]  virt_alias_binary_point_reg;
  logic [31:0] active_priorities_bitmap_reg;
  logic [31:0] rdata_reg;
  logic        deact_valid_reg;
  logic [9:0]  deact_phys_id_reg;

  logic ack_control_bit;
  logic eoi_split_mode;
  logic signal_enable;
  assign ack_control_bit = ctrl_reg[CTRL_ACK_CTL];
  assign eoi_split_mode  = ctrl_reg[CTRL_EOI_SPL];
  assign signal_enable   = ctrl_reg[CTRL_VIF_EN] & ctrl_reg[CTRL_HYP_EN];

  // ==========================================================
  // running priority
  logic       act_found;
  logic [4:0] act_idx;
  logic [7:0] virt_running_priority;

  always_comb begin
    act_found = 1'b0;
    act_idx   = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (active_priorities_bitmap_reg[i]) begin
        act_found = 1'b1;
        act_idx   = 5'(i);
      end
    end
    if (act_found) begin
      virt_running_priority = {act_idx, 3'h0};
    end else begin
      virt_running_priority = RUN_PRI_IDLE;
    end
  end

  // ==========================================================
  // highest pending selection
  logic             pend_found;
  logic [IDX_W-1:0] pend_idx;
  logic [7:0]       pend_pri;

  always_comb begin
    logic [7:0] p;
    p          = 8'h00;
    pend_found = 1'b0;
    pend_idx   = '0;
    pend_pri   = 8'hFF;
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      p = {list_entry_reg[i][LE_PRI_HI:LE_PRI_LO], 3'h0};
      // active-and-pending entries are not candidates
      if (list_entry_reg[i][LE_STATE_HI:LE_STATE_LO] == ST_PENDING) begin
        if (!pend_found || (p < pend_pri)) begin
          pend_found = 1'b1;
          pend_idx   = IDX_W'(i);
          pend_pri   = p;
        end
      end
    end
  end

  logic [31:0] win_entry;
  logic        win_group_one_bit;
  logic        win_hw;
  logic [2:0]  win_cpu;
  logic [9:0]  win_vid;
  logic [31:0] win_id_word;
  assign win_entry = list_entry_reg[pend_idx];
  assign win_group_one_bit  = win_entry[LE_GROUP_ONE_BIT];
  assign win_hw    = win_entry[LE_HW];
  assign win_cpu   = win_hw ? 3'h0 : win_entry[LE_CPU_HI:LE_CPU_LO];
  assign win_vid   = win_entry[LE_VID_HI:LE_VID_LO];
  assign win_id_word = {19'h0, win_cpu, win_vid};

  // effective binary point for the winner's group
  logic [2:0] win_bp;
  logic [7:0] win_mask;
  logic [7:0] win_group_pri;
  always_comb begin
    if (win_group_one_bit) begin
      win_bp = virt_alias_binary_point_reg - 3'h1;
    end else begin
      win_bp = bin_point_reg;
    end
  end
  assign win_mask      = group_mask(win_bp);
  assign win_group_pri = pend_pri & win_mask;

  logic win_signalled;
  assign win_signalled = pend_found && signal_enable &&
                         (pend_pri < pri_mask_reg) &&
                         (win_group_pri < virt_running_priority);

  // highest pending id word
  logic [31:0] virt_highest_pending_id;
  always_comb begin
    if (!pend_found) begin
      virt_highest_pending_id = {22'h0, ID_SPURIOUS};
    end else if (win_group_one_bit && !ack_control_bit) begin
      virt_highest_pending_id = {22'h0, ID_GROUP_ONE_BIT_HIDDEN};
    end else begin
      virt_highest_pending_id = win_id_word;
    end
  end

  // alias acknowledge outcome
  logic        ack_read;
  logic        ack_take;
  logic [31:0] virt_alias_acknowledge;
  assign ack_read = rd_en && (addr == OFF_ALIAS_ACK);
  assign ack_take = ack_read && win_signalled && win_group_one_bit;
  always_comb begin
    if (win_signalled && win_group_one_bit) begin
      virt_alias_acknowledge = win_id_word;
    end else begin
      virt_alias_acknowledge = {22'h0, ID_SPURIOUS};
    end
  end

  // ==========================================================
  // alias end of interrupt matching
  logic             eoi_write;
  logic             eoi_hit;
  logic [IDX_W-1:0] eoi_idx;
  assign eoi_write = wr_en && (addr == OFF_ALIAS_EOI);

  always_comb begin
    eoi_hit = 1'b0;
    eoi_idx = '0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
      if (is_active(list_entry_reg[i][LE_STATE_HI:LE_STATE_LO]) &&
          list_entry_reg[i][LE_GROUP_ONE_BIT] &&
          (list_entry_reg[i][LE_VID_HI:LE_VID_LO] ==
           wdata[LE_VID_HI:LE_VID_LO])) begin
        eoi_hit = 1'b1;
        eoi_idx = IDX_W'(i);
      end
    end
  end

  logic [31:0] eoi_entry;
  logic        eoi_deact;
  assign eoi_entry = list_entry_reg[eoi_idx];
  assign eoi_deact = eoi_write && eoi_hit && !eoi_split_mode;

  // acknowledge bitmap position from the winner's group priority
  logic [4:0] ack_bit;
  assign ack_bit = win_group_pri[7:3];

  // ==========================================================
  // list entries
  logic             le_write;
  logic [IDX_W-1:0] le_widx;
  logic [7:0]       le_off;
  assign le_off   = addr - OFF_LIST_BASE;
  assign le_write = wr_en && (addr >= OFF_LIST_BASE) &&
                    (32'(le_off[7:2]) < NUM_ENTRIES) &&
                    (le_off[1:0] == 2'h0);
  assign le_widx  = IDX_W'(le_off[7:2]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        list_entry_reg[i] <= 32'h0000_0000;
      end
    end else begin
      if (le_write) begin
        list_entry_reg[le_widx] <= wdata;
      end
      if (ack_take) begin
        list_entry_reg[pend_idx][LE_STATE_HI:LE_STATE_LO] <= ST_ACTIVE;
      end
      if (eoi_deact) begin
        if (eoi_entry[LE_STATE_HI:LE_STATE_LO] == ST_ACT_PEND) begin
          list_entry_reg[eoi_idx][LE_STATE_HI:LE_STATE_LO] <= ST_PENDING;
        end else begin
          list_entry_reg[eoi_idx][LE_STATE_HI:LE_STATE_LO] <= ST_INVALID;
        end
      end
    end
  end

  // ==========================================================
  // active priorities bitmap
  logic [31:0] apr_drop;
  always_comb begin
    apr_drop = 32'h0000_0000;
    if (act_found) begin
      apr_drop[act_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_priorities_bitmap_reg <= 32'h0000_0000;
    end else if (wr_en && (addr == OFF_ACT_PRI)) begin
      active_priorities_bitmap_reg <= wdata;
    end else if (ack_take) begin
      active_priorities_bitmap_reg[ack_bit] <= 1'b1;
    end else if (eoi_write) begin
      active_priorities_bitmap_reg <=
        active_priorities_bitmap_reg & ~apr_drop;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg     <= CTRL_RST;
      pri_mask_reg <= PRI_MASK_RST;
    end else if (wr_en) begin
      if (addr == OFF_CTRL) begin
        ctrl_reg <= wdata[3:0];
      end
      if (addr == OFF_PRI_MASK) begin
        pri_mask_reg <= {wdata[7:3], 3'h0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bin_point_reg               <= BIN_POINT_MIN;
      virt_alias_binary_point_reg <= ALIAS_BP_MIN;
    end else if (wr_en) begin
      if (addr == OFF_BIN_POINT) begin
        bin_point_reg <= (wdata[2:0] < BIN_POINT_MIN) ?
                         BIN_POINT_MIN : wdata[2:0];
      end
      if (addr == OFF_ALIAS_BP) begin
        virt_alias_binary_point_reg <= (wdata[2:0] < ALIAS_BP_MIN) ?
                                       ALIAS_BP_MIN : wdata[2:0];
      end
    end
  end

  // ==========================================================
  // distributor deactivate request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      deact_valid_reg   <= 1'b0;
      deact_phys_id_reg <= 10'h000;
    end else begin
      deact_valid_reg <= eoi_deact && eoi_entry[LE_HW] &&
                         eoi_entry[LE_GROUP_ONE_BIT];
      if (eoi_deact && eoi_entry[LE_HW]) begin
        deact_phys_id_reg <= eoi_entry[LE_PID_HI:LE_PID_LO];
      end
    end
  end

  // ==========================================================
  // read data, valid in the cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr)
      OFF_CTRL:      rd_mux = {28'h0, ctrl_reg};
      OFF_PRI_MASK:  rd_mux = {24'h0, pri_mask_reg};
      OFF_BIN_POINT: rd_mux = {29'h0, bin_point_reg};
      OFF_ALIAS_BP:  rd_mux = {29'h0, virt_alias_binary_point_reg};
      OFF_RUN_PRI:   rd_mux = {24'h0, virt_running_priority};
      OFF_HIGH_PEND: rd_mux = virt_highest_pending_id;
      OFF_ALIAS_ACK: rd_mux = virt_alias_acknowledge;
      OFF_ACT_PRI:   rd_mux = active_priorities_bitmap_reg;
      default: begin
        if ((addr >= OFF_LIST_BASE) && (le_off[1:0] == 2'h0) &&
            (32'(le_off[7:2]) < NUM_ENTRIES)) begin
          rd_mux = list_entry_reg[le_widx];
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata         = rdata_reg;
  assign deact_valid   = deact_valid_reg;
  assign deact_phys_id = deact_phys_id_reg;

endmodule

// ---- src/virt_cpu_if_pkg.sv ----
package virt_cpu_if_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_PRI_MASK  = 8'h04;
  localparam logic [7:0] OFF_BIN_POINT = 8'h08;
  localparam logic [7:0] OFF_ALIAS_BP  = 8'h0C;
  localparam logic [7:0] OFF_RUN_PRI   = 8'h10;
  localparam logic [7:0] OFF_HIGH_PEND = 8'h14;
  localparam logic [7:0] OFF_ALIAS_ACK = 8'h18;
  localparam logic [7:0] OFF_ALIAS_EOI = 8'h1C;
  localparam logic [7:0] OFF_ACT_PRI   = 8'h20;
  localparam logic [7:0] OFF_LIST_BASE = 8'h40;

  // ==========================================================
  // control register bit positions
  localparam int CTRL_VIF_EN  = 0;
  localparam int CTRL_ACK_CTL = 1;
  localparam int CTRL_EOI_SPL = 2;
  localparam int CTRL_HYP_EN  = 3;

  // ==========================================================
  // list entry layout
  localparam int LE_VID_LO   = 0;
  localparam int LE_VID_HI   = 9;
  localparam int LE_PID_LO   = 10;
  localparam int LE_PID_HI   = 19;
  localparam int LE_CPU_LO   = 10;
  localparam int LE_CPU_HI   = 12;
  localparam int LE_PRI_LO   = 23;
  localparam int LE_PRI_HI   = 27;
  localparam int LE_STATE_LO = 28;
  localparam int LE_STATE_HI = 29;
  localparam int LE_GROUP_ONE_BIT     = 30;
  localparam int LE_HW       = 31;

  localparam logic [1:0] ST_INVALID  = 2'h0;
  localparam logic [1:0] ST_PENDING  = 2'h1;
  localparam logic [1:0] ST_ACTIVE   = 2'h2;
  localparam logic [1:0] ST_ACT_PEND = 2'h3;

  // ==========================================================
  // identifiers and reset values
  localparam logic [9:0]  ID_GROUP_ONE_BIT_HIDDEN = 10'h3FE;
  localparam logic [9:0]  ID_SPURIOUS    = 10'h3FF;
  localparam logic [7:0]  RUN_PRI_IDLE   = 8'hF8;
  localparam logic [2:0]  BIN_POINT_MIN  = 3'h2;
  localparam logic [2:0]  ALIAS_BP_MIN   = 3'h3;
  localparam logic [7:0]  PRI_MASK_RST   = 8'h00;
  localparam logic [3:0]  CTRL_RST       = 4'h0;

endpackage
